/* inc/ddrd_map.svh */
/*
 * constants of the dual-line ddr read handler: command codes, phase
 * lengths, latency tables, array size and buffer shape.
 * assumes it is included by bare name wherever a constant is needed.
 */
//==============================================================
// Behaviour
// - BDh takes three or four address bytes
// - BEh always takes four address bytes
// - data leaves two bits per edge
// - address and mode arrive two bits per edge
// - latency clocks set by latency code
// - basic table: instruction, address, latency, no mode
// - inputs ignored during latency clocks
// - complementary mode nibbles enter continuous mode
// - other mode nibbles leave continuous mode
// - short invalid frame leaves continuous mode
// - address counter advances once per byte
// - counter wraps from top to zero
// - pause input has no effect
// - pattern fills last seven latency edges
// - same pattern bits 7 down to 1 on both lines
`ifndef DDRD_MAP_SVH
`define DDRD_MAP_SVH

//==============================================================
// command codes
`define DDRD_CMD_READ 8'hbd
`define DDRD_CMD_READ4 8'hbe

//==============================================================
// phase lengths, in serial clock edges unless noted
`define DDRD_INSTR_BITS 6'h08
`define DDRD_ADDR3_EDGES 6'h0c
`define DDRD_ADDR4_EDGES 6'h10
`define DDRD_MODE_EDGES 6'h04
`define DDRD_PREAMBLE_EDGES 6'h08
`define DDRD_SHORT_FRAME_RISES 4'h8
`define DDRD_SCK_MAX_MHZ 80

//==============================================================
// latency clocks per latency code, basic and extended tables
`define DDRD_LAT_BASIC0 5'h05
`define DDRD_LAT_BASIC1 5'h06
`define DDRD_LAT_BASIC2 5'h07
`define DDRD_LAT_BASIC3 5'h08
`define DDRD_LAT_EXT0 5'h04
`define DDRD_LAT_EXT1 5'h05
`define DDRD_LAT_EXT2 5'h06
`define DDRD_LAT_EXT3 5'h07

//==============================================================
// array and buffer
`define DDRD_ADDR_MAX 32'h03ff_ffff
`define DDRD_FIFO_DEPTH 32
`define DDRD_FIFO_WIDTH 8

`endif

/* inc/ddrd_pkg.sv */
/*
 * types of the dual-line ddr read handler.
 * assumes the constants header sits beside it.
 */
//==============================================================
// package
package ddrd_pkg;
   // frame phases, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01, // select high
      ST_INSTR = 7'h02, // single-rate instruction
      ST_ADDR = 7'h04, // double-rate address
      ST_MODE = 7'h08, // double-rate mode byte
      ST_DUMMY = 7'h10, // latency, optional pattern
      ST_DATA = 7'h20, // array data out
      ST_IGNORE = 7'h40 // foreign command, wait for select high
   } ddrd_state_type;
endpackage

/* sim/ddrd_host.sv */
/*
 * host controller model: drives serial clock, select and io lines of
 * the dual-line ddr read and samples what the device drives.
 * assumes the bench resolves the io wires and feeds them back.
 */
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// host model
module ddrd_host (
   input wire logic i_mclk,
   input wire logic [1:0] i_io, // resolved lines
   input wire logic [1:0] i_oe, // device drive enables
   output logic o_sck,
   output logic o_csn,
   output logic [1:0] o_io,
   output logic o_oe
);
   logic [3:0] smp; // {oe, io} just before a toggle
   initial begin
      o_sck = 1'b0;
      o_csn = 1'b1;
      o_io = 2'h0;
      o_oe = 1'b0;
   end
   // one edge: data set mid half period, so both sides of the
   // device synchroniser see it stable; sample just before toggle
   task automatic step(input logic [1:0] v, input logic drv);
      o_io <= drv ? v : o_io;
      o_oe <= drv;
      repeat (2) @(posedge i_mclk);
      // fixed late capture point; the preamble compare confirms it
      #1 smp = {i_oe, i_io};
      o_sck <= ~o_sck;
      repeat (2) @(posedge i_mclk);
   endtask
   // whole read frame; s[j] holds the lines after edge j past
   // the instruction
   task automatic frame(input logic c, input logic [7:0] cmd,
      input int ae, input logic [31:0] a, input int me,
      input logic [7:0] m, input int le, output logic [3:0] s [64]);
      int k;
      int t;
      t = ae + me + le + 16;
      @(posedge i_mclk);
      o_csn <= 1'b0;
      repeat (4) @(posedge i_mclk);
      if (!c) begin
         for (k = 7; k >= 0; k--) begin
            step({1'b0, cmd[k]}, 1'b1);
            step(o_io, 1'b1);
         end
      end
      for (k = 0; k < t; k++) begin
         if (k < ae)
            step(a[2 * (ae - 1 - k) +: 2], 1'b1);
         else if (k < ae + me)
            step(m[2 * (ae + me - 1 - k) +: 2], 1'b1);
         else
            step(2'h0, 1'b0);
         if (k > 0)
            s[k - 1] = smp;
      end
      repeat (2) @(posedge i_mclk);
      #1 s[t - 1] = {i_oe, i_io};
      @(posedge i_mclk);
      o_csn <= 1'b1;
      o_oe <= 1'b0;
      repeat (6) @(posedge i_mclk);
   endtask
   // select low for n address edges only
   task automatic brief(input int n);
      @(posedge i_mclk);
      o_csn <= 1'b0;
      repeat (4) @(posedge i_mclk);
      for (int k = 0; k < n; k++)
         step(2'h1, 1'b1);
      o_csn <= 1'b1;
      repeat (6) @(posedge i_mclk);
   endtask
endmodule // ddrd_host
`default_nettype wire

/* sim/ddrd_read_tb.sv */
/*
 * bench of the dual-line ddr read: table of reads, then continuous
 * mode, wrap, both exits and a foreign command.
 * assumes the design files and the map header are on the path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ddrd_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   miscompares++; $display("[FAIL] %0t got %h want %h", $time, g, e); \
   end end
//==============================================================
// bench
module ddrd_read_tb;
   typedef struct {logic c; logic [7:0] cmd; logic f; logic x;
      logic [1:0] l; logic e; logic [7:0] p; logic [31:0] a;
      logic [7:0] m;} ddrd_row_type;
   logic i_mclk = 0;
   logic i_resetn = 0;
   logic sck, csn, h_oe, rd, cont, fba = 0, ext = 0, learn = 0;
   logic valid = 0;
   logic [1:0] h_io, io, d_io, d_oe, lc = 0, oe_any = 0;
   logic [7:0] pat = 8'h34, adata = 8'h00;
   logic [31:0] aaddr;
   logic [3:0] s [64];
   int miscompares = 0;
   int samples_checked = 0;
   ddrd_row_type rows [6] = '{
      '{0, 8'hbd, 0, 0, 2'h0, 1, 8'h34, 32'h0000_0010, 8'h00},
      '{0, 8'hbd, 0, 0, 2'h1, 1, 8'h34, 32'hff12_3456, 8'h00},
      '{0, 8'hbe, 0, 0, 2'h2, 0, 8'h34, 32'h0000_ff00, 8'h00},
      '{0, 8'hbd, 1, 0, 2'h3, 0, 8'h34, 32'h0123_4567, 8'h00},
      '{0, 8'hbe, 0, 1, 2'h1, 1, 8'hc5, 32'h00ff_fffe, 8'h00},
      '{0, 8'hbd, 1, 1, 2'h2, 1, 8'h34, 32'h0200_0000, 8'ha5}};
   always #12.5 i_mclk = ~i_mclk;
   // released line shows the inverse of its last value
   assign io = (d_oe & d_io) | (~d_oe & (h_oe ? h_io : ~h_io));
   function automatic logic [7:0] f(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   // array answers each request one cycle later
   always @(posedge i_mclk) begin
      valid <= rd;
      adata <= f(aaddr);
   end
   ddrd_host i_ddrd_host (.i_mclk(i_mclk), .i_io(io), .i_oe(d_oe),
      .o_sck(sck), .o_csn(csn), .o_io(h_io), .o_oe(h_oe));
   ddrd_read i_ddrd_read (.i_mclk(i_mclk), .i_resetn(i_resetn),
      .i_sck(sck), .i_csn(csn), .i_io(io), .o_io(d_io), .o_io_oe(d_oe),
      .i_four_byte_address_select(fba), .i_extended_latency_table(ext),
      .i_latency_code(lc), .i_learning_enable(learn),
      .i_learning_pattern(pat), .o_array_rd(rd), .o_array_addr(aaddr),
      .i_array_valid(valid), .i_array_data(adata), .o_continuous(cont));
   task automatic test_done;
      $display("checked %0d miscompares %0d", samples_checked,
         miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one read: expected lines worked out from the row
   task automatic run(input ddrd_row_type r);
      int ae, me, le, ix;
      logic [31:0] ea;
      logic [7:0] b;
      @(posedge i_mclk);
      fba <= r.f;
      ext <= r.x;
      lc <= r.l;
      learn <= r.e;
      pat <= r.p;
      ae = (r.cmd == `DDRD_CMD_READ4 || r.f) ? 16 : 12;
      me = r.x ? 4 : 0;
      le = 2 * (r.l + (r.x ? 4 : 5));
      ea = (ae == 12) ? {8'h00, r.a[23:0]} : r.a;
      i_ddrd_host.frame(r.c, r.cmd, ae, ea, me, r.m, le, s);
      for (int k = 1; k < le; k++) begin
         ix = ae + me + k - 1;
         if (r.e && k >= le - 7)
            `CHK(s[ix], {2'b11, {2{r.p[le - k]}}})
         else
            `CHK(s[ix][3:2], 2'b00)
      end
      for (int q = 0; q < 16; q++) begin
         ix = ae + me + le - 1 + q;
         b = f((ea + q / 4) & `DDRD_ADDR_MAX);
         `CHK(s[ix], {2'b11, b[7 - 2 * (q % 4) -: 2]})
      end
      $display("read %h at %h done", r.cmd, ea);
   endtask
   initial begin
      repeat (2) @(posedge i_mclk);
      `CHK(d_oe, 2'b00)
      `CHK(cont, 1'b0)
      $display("reset test done");
      i_resetn <= 1'b1;
      repeat (6) @(posedge i_mclk);
      foreach (rows[i])
         run(rows[i]);
      `CHK(cont, 1'b1)
      run('{1, 8'hbe, 1, 1, 2'h3, 1, 8'h34, 32'h03ff_fffe, 8'h5a});
      `CHK(cont, 1'b1)
      run('{1, 8'hbe, 1, 1, 2'h0, 0, 8'h34, 32'h0000_0100, 8'h12});
      `CHK(cont, 1'b0)
      run(rows[5]);
      `CHK(cont, 1'b1)
      i_ddrd_host.brief(4);
      `CHK(cont, 1'b0)
      $display("exit tests done");
      i_ddrd_host.frame(0, 8'h03, 12, 0, 0, 0, 10, s);
      for (int k = 0; k < 38; k++)
         oe_any = oe_any | s[k][3:2];
      `CHK(oe_any, 2'b00)
      $display("foreign command done");
      test_done;
   end
   // watchdog so a hang still reaches the verdict
   initial begin
      repeat (40000) @(posedge i_mclk);
      miscompares++;
      test_done;
   end
endmodule // ddrd_read_tb
`default_nettype wire

/* verilog/ddrd_fifo.sv */
/*
 * small synchronous fifo with valid and ready on both sides.
 * assumes flush and push never matter in the same cycle (flush wins).
 */
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// fifo
module ddrd_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_flush,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D]; // storage flops
   logic [AW-1:0] wptr, next_wptr; // write index
   logic [AW-1:0] rptr, next_rptr; // read index
   logic [AW:0] count, next_count; // words held
   logic push, pop;

   assign o_in_ready = (count != (AW+1)'(D));
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rptr];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // pointer arithmetic; depth is a power of two so indices wrap freely
   always_comb begin
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      if (i_flush) begin
         next_wptr = '0;
         next_rptr = '0;
         next_count = '0;
      end
   end

   // register pointers
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
      end
   end

   // storage has no reset; contents are invalid until written
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wptr] <= i_in_data;
      end
   end
endmodule // ddrd_fifo
`default_nettype wire

/* verilog/ddrd_read.sv */
/*
 * dual-line double-rate read handler of a serial flash: decodes the
 * instruction, gathers address and mode, counts latency, drives the
 * learning preamble and streams array bytes from a prefetch fifo.
 * assumes the array port answers each one-cycle request with one
 * i_array_valid pulse later, and the serial clock is far below i_mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ddrd_map.svh"
//==============================================================
// top
module ddrd_read (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_sck, // serial clock pin
   input wire logic i_csn, // chip select pin, low active
   input wire logic [1:0] i_io, // io lines, input side
   output logic [1:0] o_io, // io lines, output side
   output logic [1:0] o_io_oe, // high while the device drives
   input wire logic i_four_byte_address_select,
   input wire logic i_extended_latency_table,
   input wire logic [1:0] i_latency_code,
   input wire logic i_learning_enable,
   input wire logic [7:0] i_learning_pattern,
   output logic o_array_rd, // one-cycle read request
   output logic [31:0] o_array_addr,
   input wire logic i_array_valid,
   input wire logic [7:0] i_array_data,
   output logic o_continuous
);
   //===========================================================
   // pin capture and edge finding
   logic [3:0] pins_s;
   logic sck_s, csn_s, sck_d, csn_d;
   logic [1:0] io_s;
   ddrd_sync #(.W(4)) u_sync (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_async({i_sck, i_csn, i_io}),
      .o_sync(pins_s)
   );
   assign sck_s = pins_s[3];
   assign csn_s = pins_s[2];
   assign io_s = pins_s[1:0];

   // one flop behind the synchronised levels, for edges
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         sck_d <= 1'b1; // matches the synchroniser's reset level
         csn_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
         csn_d <= csn_s;
      end
   end

   logic sck_rise, sck_fall, sck_edge, cs_rise, cs_fall;
   assign sck_rise = sck_s & ~sck_d;
   assign sck_fall = ~sck_s & sck_d;
   assign sck_edge = (sck_rise | sck_fall) & ~csn_s;
   assign cs_rise = csn_s & ~csn_d;
   assign cs_fall = ~csn_s & csn_d;

   //===========================================================
   // frame state
   ddrd_pkg::ddrd_state_type state, next_state;
   logic [5:0] cnt, next_cnt; // edges or bits in the phase
   logic [5:0] dnum, next_dnum; // latency length in edges
   logic [31:0] sh, next_sh; // address and instruction shifter
   logic [7:0] mode, next_mode; // mode byte
   logic four, next_four; // address is four bytes
   logic cont, next_cont; // continuous mode
   logic mode_done, next_mode_done; // mode byte taken this frame
   logic [3:0] rises, next_rises; // rising edges, saturating
   logic [1:0] out, next_out; // io drive value
   logic [1:0] oe, next_oe; // io drive enable
   logic [7:0] dbyte, next_dbyte; // byte being shifted out
   logic [1:0] bp, next_bp; // bit pair within the byte
   logic start_fetch; // latency begins, prefetch starts
   logic pop; // take a byte from the fifo
   logic fifo_valid, fifo_in_ready;
   logic [7:0] fifo_data;
   logic [31:0] load_addr;
   logic mode_comp;

   assign mode_comp = (mode[7:4] == ~mode[3:0]);

   // latency clocks from the selected table
   function automatic logic [4:0] lat_clocks(input logic ext,
                                             input logic [1:0] code);
      logic [4:0] n;
      n = `DDRD_LAT_BASIC0;
      case (code)
         2'h0: n = ext ? `DDRD_LAT_EXT0 : `DDRD_LAT_BASIC0;
         2'h1: n = ext ? `DDRD_LAT_EXT1 : `DDRD_LAT_BASIC1;
         2'h2: n = ext ? `DDRD_LAT_EXT2 : `DDRD_LAT_BASIC2;
         default: n = ext ? `DDRD_LAT_EXT3 : `DDRD_LAT_BASIC3;
      endcase
      return n;
   endfunction

   // next frame state; the pause pin is absent on purpose
   always_comb begin
      logic [5:0] j;
      logic [5:0] k;
      logic [5:0] aedges;
      logic go_data;
      j = cnt + 6'h01;
      k = j - (dnum - `DDRD_PREAMBLE_EDGES);
      aedges = four ? `DDRD_ADDR4_EDGES : `DDRD_ADDR3_EDGES;
      go_data = 1'b0;
      next_state = state;
      next_cnt = cnt;
      next_sh = sh;
      next_mode = mode;
      next_four = four;
      next_cont = cont;
      next_mode_done = mode_done;
      next_rises = rises;
      next_out = out;
      next_oe = oe;
      next_dbyte = dbyte;
      next_bp = bp;
      start_fetch = 1'b0;
      pop = 1'b0;
      if (cs_rise) begin
         // frame over: release lines and settle continuous mode
         next_state = ddrd_pkg::ST_IDLE;
         next_oe = 2'b00;
         if (mode_done) begin
            next_cont = mode_comp;
         end else if (cont && rises <= `DDRD_SHORT_FRAME_RISES &&
                      state == ddrd_pkg::ST_ADDR) begin
            next_cont = 1'b0;
         end
      end else if (cs_fall) begin
         // continuous mode skips the instruction
         next_state = cont ? ddrd_pkg::ST_ADDR : ddrd_pkg::ST_INSTR;
         next_cnt = '0;
         next_sh = '0;
         next_rises = '0;
         next_mode_done = 1'b0;
         next_bp = '0;
      end else if (sck_edge) begin
         if (sck_rise && rises != 4'hf) begin
            next_rises = rises + 4'h1;
         end
         case (state)
            ddrd_pkg::ST_INSTR: begin
               // single-rate, rising edges only, line 0
               if (sck_rise) begin
                  next_sh = {sh[30:0], io_s[0]};
                  next_cnt = j;
                  if (j == `DDRD_INSTR_BITS) begin
                     next_cnt = '0;
                     next_state = ddrd_pkg::ST_ADDR;
                     if (next_sh[7:0] == `DDRD_CMD_READ) begin
                        next_four = i_four_byte_address_select;
                     end else if (next_sh[7:0] == `DDRD_CMD_READ4) begin
                        next_four = 1'b1;
                     end else begin
                        next_state = ddrd_pkg::ST_IGNORE;
                     end
                  end
               end
            end
            ddrd_pkg::ST_ADDR: begin
               // two bits per edge from the first rising edge on
               if (cnt != '0 || sck_rise) begin
                  next_sh = {sh[29:0], io_s[1], io_s[0]};
                  next_cnt = j;
                  if (j == aedges) begin
                     next_cnt = '0;
                     if (i_extended_latency_table) begin
                        next_state = ddrd_pkg::ST_MODE;
                     end else begin
                        next_state = ddrd_pkg::ST_DUMMY;
                        start_fetch = 1'b1;
                     end
                  end
               end
            end
            ddrd_pkg::ST_MODE: begin
               next_mode = {mode[5:0], io_s[1], io_s[0]};
               next_cnt = j;
               if (j == `DDRD_MODE_EDGES) begin
                  next_cnt = '0;
                  next_mode_done = 1'b1;
                  next_state = ddrd_pkg::ST_DUMMY;
                  start_fetch = 1'b1;
               end
            end
            ddrd_pkg::ST_DUMMY: begin
               // io inputs are not looked at here
               next_cnt = j;
               if (j == dnum) begin
                  go_data = 1'b1;
               end else if (i_learning_enable &&
                            j > dnum - `DDRD_PREAMBLE_EDGES) begin
                  next_oe = 2'b11;
                  next_out = {2{i_learning_pattern[3'(7 - k + 1)]}};
               end
            end
            ddrd_pkg::ST_DATA: begin
               go_data = 1'b1;
            end
            ddrd_pkg::ST_IGNORE: begin
               next_state = ddrd_pkg::ST_IGNORE;
            end
            default: begin
               next_state = ddrd_pkg::ST_IDLE;
            end
         endcase
         if (go_data) begin
            // a byte every four edges, msb pair first
            next_state = ddrd_pkg::ST_DATA;
            next_oe = 2'b11;
            next_bp = bp + 2'h1;
            if (bp == 2'h0) begin
               pop = 1'b1;
               next_out = fifo_data[7:6];
               next_dbyte = {fifo_data[5:0], 2'b00};
            end else begin
               next_out = dbyte[7:6];
               next_dbyte = {dbyte[5:0], 2'b00};
            end
         end
      end
   end

   // the latency length is latched as the dummy phase starts
   always_comb begin
      load_addr = four ? next_sh : {8'h00, next_sh[23:0]};
      if (start_fetch) begin
         next_dnum = {lat_clocks(i_extended_latency_table,
                                 i_latency_code), 1'b0};
      end else begin
         next_dnum = dnum;
      end
   end

   // register frame state
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ddrd_pkg::ST_IDLE;
         cnt <= '0;
         dnum <= 6'h08;
         sh <= '0;
         mode <= '0;
         four <= 1'b0;
         cont <= 1'b0;
         mode_done <= 1'b0;
         rises <= '0;
         out <= 2'b00;
         oe <= 2'b00;
         dbyte <= '0;
         bp <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         dnum <= next_dnum;
         sh <= next_sh;
         mode <= next_mode;
         four <= next_four;
         cont <= next_cont;
         mode_done <= next_mode_done;
         rises <= next_rises;
         out <= next_out;
         oe <= next_oe;
         dbyte <= next_dbyte;
         bp <= next_bp;
      end
   end

   assign o_io = out;
   assign o_io_oe = oe;
   assign o_continuous = cont;

   //===========================================================
   // array prefetch into the fifo
   logic fetch_on, next_fetch_on; // prefetch enabled
   logic pending, next_pending; // one request in flight
   logic [31:0] addr_ctr, next_addr_ctr; // next array address
   logic issue;

   // only one request in flight, so fifo space is reserved at issue;
   // a full fifo stalls the counter rather than dropping bytes
   assign issue = fetch_on & ~pending & fifo_in_ready;
   assign o_array_rd = issue;
   assign o_array_addr = addr_ctr;

   // prefetch next values
   always_comb begin
      next_fetch_on = fetch_on;
      next_pending = pending;
      next_addr_ctr = addr_ctr;
      if (i_array_valid) begin
         next_pending = 1'b0;
      end
      if (issue) begin
         next_pending = 1'b1;
         if (addr_ctr == `DDRD_ADDR_MAX) begin
            next_addr_ctr = '0;
         end else begin
            next_addr_ctr = addr_ctr + 32'h1;
         end
      end
      if (start_fetch) begin
         next_fetch_on = 1'b1;
         next_addr_ctr = load_addr;
      end
      if (cs_rise) begin
         next_fetch_on = 1'b0;
      end
   end

   // register prefetch state
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         fetch_on <= 1'b0;
         pending <= 1'b0;
         addr_ctr <= '0;
      end else begin
         fetch_on <= next_fetch_on;
         pending <= next_pending;
         addr_ctr <= next_addr_ctr;
      end
   end

   ddrd_fifo #(.W(`DDRD_FIFO_WIDTH), .D(`DDRD_FIFO_DEPTH)) u_fifo (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_flush(cs_rise),
      .i_in_valid(i_array_valid & fetch_on),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_array_data),
      .o_out_valid(fifo_valid),
      .i_out_ready(pop),
      .o_out_data(fifo_data)
   );

   //===========================================================
   // checks
   a_bd_width: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state == ddrd_pkg::ST_INSTR && next_state == ddrd_pkg::ST_ADDR &&
       next_sh[7:0] == `DDRD_CMD_READ) |=>
      (four == $past(i_four_byte_address_select)))
      else $error("address width wrong after read command");
   a_be_width: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state == ddrd_pkg::ST_INSTR && next_state == ddrd_pkg::ST_ADDR &&
       next_sh[7:0] == `DDRD_CMD_READ4) |=> four)
      else $error("four-byte command took a short address");
   a_mode_table: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state == ddrd_pkg::ST_ADDR && next_state != ddrd_pkg::ST_ADDR &&
       !cs_rise && !cs_fall && !i_extended_latency_table) |=>
      (state == ddrd_pkg::ST_DUMMY))
      else $error("mode phase entered with basic table");
   a_dummy_quiet: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state == ddrd_pkg::ST_DUMMY && !i_learning_enable &&
       $past(state) == ddrd_pkg::ST_DUMMY) |-> (o_io_oe == 2'b00))
      else $error("lines driven in latency without pattern");
   a_pattern_same: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (state == ddrd_pkg::ST_DUMMY && o_io_oe == 2'b11) |->
      (o_io[1] == o_io[0]))
      else $error("preamble differs between lines");
   a_byte_pop: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (pop && !cs_rise) |=> (o_io == $past(fifo_data[7:6])) ##0
      (o_io_oe == 2'b11))
      else $error("first pair of a byte not driven");
   a_cont_enter: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (cs_rise && mode_done && mode_comp) |=> o_continuous)
      else $error("complementary mode did not enter continuous");
   a_cont_leave: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (cs_rise && mode_done && !mode_comp) |=> !o_continuous)
      else $error("non-complementary mode kept continuous");
   a_short_exit: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (cs_rise && !mode_done && cont && state == ddrd_pkg::ST_ADDR &&
       rises <= `DDRD_SHORT_FRAME_RISES) |=> !o_continuous)
      else $error("short frame kept continuous mode");
   a_addr_step: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (issue && !start_fetch && addr_ctr != `DDRD_ADDR_MAX) |=>
      (o_array_addr == $past(addr_ctr) + 32'h1))
      else $error("address did not advance by one");
   a_addr_wrap: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      (issue && !start_fetch && addr_ctr == `DDRD_ADDR_MAX) |=>
      (o_array_addr == 32'h0))
      else $error("address did not wrap to zero");
   // a pop from an empty buffer would repeat stale bytes out of order
   a_no_underrun: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      pop |-> fifo_valid)
      else $error("byte taken from an empty prefetch buffer");
   c_cont: cover property (@(posedge i_mclk) cs_fall && cont);
   c_data: cover property (@(posedge i_mclk) state == ddrd_pkg::ST_DATA);
   c_pattern: cover property (@(posedge i_mclk)
      state == ddrd_pkg::ST_DUMMY && o_io_oe == 2'b11);
   c_wrap: cover property (@(posedge i_mclk)
      issue && addr_ctr == `DDRD_ADDR_MAX);
endmodule // ddrd_read
`default_nettype wire

/* verilog/ddrd_sync.sv */
/*
 * two-flop synchronisers for pins from outside the clock domain.
 * assumes each bit is an independent level.
 */
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// synchroniser
module ddrd_sync #(
   parameter int W = 4
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   genvar g;
   // one pair of flops per bit; first stage feeds only the second
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         logic meta;
         logic steady;
         always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
               meta <= 1'b1;
               steady <= 1'b1;
            end else begin
               meta <= i_async[g];
               steady <= meta;
            end
         end
         assign o_sync[g] = steady;
      end
   endgenerate
endmodule // ddrd_sync
`default_nettype wire
